// File: design/lcd_pkg.sv
// constants, types and lookups of the panel controller
// assumes a 50 MHz system clock and byte-wide registers on a 32-bit bus
`default_nettype none
package lcd_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS   = 20;   // system clock period
	localparam int BYTE_NS  = 250;  // one byte, byte mode
	localparam int NIB_NS   = 375;  // one byte, nibble mode
	localparam int BIT_NS   = 1125; // one byte, bit mode
	localparam int LATCH_NS = 100;  // latch pulse width
	// cycles per shift step, rounded down, never below one
	localparam logic [5:0] PER_BYTE  = 6'((BYTE_NS / CLK_NS) > 0 ? BYTE_NS / CLK_NS : 1);
	localparam logic [5:0] PER_NIB   = 6'((NIB_NS / (2 * CLK_NS)) > 0 ? NIB_NS / (2 * CLK_NS) : 1);
	localparam logic [5:0] PER_BIT   = 6'((BIT_NS / (8 * CLK_NS)) > 0 ? BIT_NS / (8 * CLK_NS) : 1);
	localparam logic [2:0] LATCH_CYC = 3'((LATCH_NS + CLK_NS - 1) / CLK_NS);
	// ----------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [9:0] IDX_SAL  = 10'h360;
	localparam logic [9:0] IDX_SAH  = 10'h361;
	localparam logic [9:0] IDX_SIZE = 10'h362;
	localparam logic [9:0] IDX_CTL  = 10'h363;
	localparam logic [9:0] IDX_FFP  = 10'h364;
	localparam logic [9:0] IDX_CTL2 = 10'h366;
	localparam logic [9:0] IDX_STAT = 10'h36F;
	localparam logic [9:0] IDX_ECC  = 10'h0E7;
	localparam logic [7:0] REG_RST  = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SAL_MODE  = 0; // 1 = serial shift mode
	localparam int CTL_START = 0;
	localparam int CTL_FP8   = 1;
	localparam int CTL_MAP   = 2; // ram_direct_map_en
	localparam int CTL_WLO   = 3; // xfer_width_lo, hi at 4
	localparam int CTL_ON    = 7; // display_on_bit
	localparam int ECC_PANEL = 0; // panel_clk_timer_sel
	localparam int CTL2_ACLO = 0; // access_type_lo, hi at 1
	localparam int CTL2_WORD = 2; // ram_mode_word_sel
	localparam logic [1:0] W_BYTE = 2'h0;
	localparam logic [1:0] W_NIB  = 2'h1;
	localparam logic [1:0] W_BIT  = 2'h2;
	// driver address areas
	localparam logic [20:0] SEQ_TAG = 21'h0001FC; // 0xFE0..0xFE7
	localparam logic [5:0]  RND_TAG = 6'h0F;      // 0x3C0000..0x3FFFFF
	// ----------------------------------------
	// fsm
	// ----------------------------------------
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_REQ   = 5'b00010,
		S_FETCH = 5'b00100,
		S_SHIFT = 5'b01000,
		S_LINE  = 5'b10000
	} lcd_state_t;
	// panel rows from row_count_field, reserved codes fall back to 64
	function automatic logic [7:0] lcd_rows(input logic [3:0] c);
		case (c)
			4'h1: lcd_rows = 8'd68;
			4'h2: lcd_rows = 8'd80;
			4'h3: lcd_rows = 8'd100;
			4'h4: lcd_rows = 8'd120;
			4'h5: lcd_rows = 8'd128;
			4'h6: lcd_rows = 8'd144;
			4'h7: lcd_rows = 8'd160;
			4'h8: lcd_rows = 8'd200;
			4'h9: lcd_rows = 8'd240;
			default: lcd_rows = 8'd64;
		endcase
	endfunction
	// bytes per line from column_count_field (columns / 8), reserved -> 32 cols
	function automatic logic [5:0] lcd_cols(input logic [3:0] c);
		case (c)
			4'h1: lcd_cols = 6'd8;
			4'h2: lcd_cols = 6'd10;
			4'h3: lcd_cols = 6'd15;
			4'h4: lcd_cols = 6'd16;
			4'h5: lcd_cols = 6'd20;
			4'h6: lcd_cols = 6'd30;
			4'h7: lcd_cols = 6'd40;
			4'h8: lcd_cols = 6'd45;
			default: lcd_cols = 6'd4;
		endcase
	endfunction
endpackage
`default_nettype wire

// File: design/lcd_ctrl.sv
// panel driver controller: serial shift mode frame fetch and ram mode chip enables
// assumes bus grant, memory answers and cpu access strobes on clk_i;
// the low-frequency clock and timer 3 output arrive asynchronously
//
// Contract
// - start requests bus, fetches frame, releases bus
// - ram mode cpu access raises matching enable
// - ext clock bit0 picks timer3 over oscillator
// - row field encodes ten panel row counts
// - column field encodes nine column counts
// - byte time 250, 375, 1125 ns (a byte's shift steps here take 240, 360, 1120 ns, rounded down to whole cycles)
// - unused upper data lines carry nothing
// - data stable at shift clock falling edge
// - latch pulse rising edge loads driver buffers
// - cascade pulses once per frame level change
// - display output follows display on bit
// - lowest address marks data or instruction
// - four pulse pins reused as chip enables
// - write strobe only in ram mode
// - fetch offset low 14 bits start zero
// - nine bit frame length, bit8 in control
// - ram word select and access type stored
// - frame inverts each frame length lines
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl
	import lcd_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:2] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// panel clock sources (asynchronous)
	input  wire logic        lf_clk_i,
	input  wire logic        timer3_output_i,
	// bus request and frame memory
	output logic             bus_req_o,
	input  wire logic        bus_grant_i,
	output logic             mem_rd_o,
	output logic      [23:0] mem_adr_o,
	input  wire logic [7:0]  mem_dat_i,
	input  wire logic        mem_ack_i,
	// cpu move accesses in ram mode
	input  wire logic        cpu_acc_i,
	input  wire logic        cpu_we_i,
	input  wire logic [23:0] cpu_adr_i,
	// driver pins
	output logic      [7:0]  lcd_data_o,
	output logic             shift_clk_or_ce1_o,
	output logic             latch_pulse_or_ce2_o,
	output logic             frame_out_or_ce3_o,
	output logic             cascade_pulse_or_row_ce_o,
	output logic             display_off_out_o,
	output logic             lcd_a0_o,
	output logic             lcd_wr_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  sal;       // start addr low + mode
		logic [7:0]  sah;       // start addr high
		logic [7:0]  size;      // row/column fields
		logic [7:0]  ctl;       // display control
		logic [7:0]  frame_length;       // frame length low
		logic [7:0]  ctl2;      // ram mode control
		logic [7:0]  ecc;       // ext clock control
		logic [1:0]  lf_sync;   // oscillator synchroniser
		logic [1:0]  t3_sync;   // timer synchroniser
		logic        src_prev;  // selected source, last cycle
		lcd_state_t  st;        // transfer fsm
		logic [13:0] ofs;       // fetch offset
		logic [7:0]  sh;        // byte being shifted
		logic [2:0]  step;      // step within byte
		logic [5:0]  per;       // cycle within step
		logic [5:0]  col;       // byte within line
		logic [7:0]  row;       // line within frame
		logic [8:0]  line;      // line count for frame period
		logic [2:0]  lp;        // latch pulse cycles left
		logic        frame_lvl; // frame polarity
		logic        cd;        // cascade pulse
		logic        sclk;      // shift clock
		logic [3:0]  ram_ce;    // ram mode enables
		logic [1:0]  hold;      // ram strobe hold
		logic        ack;
		logic [7:0]  dat;
		logic        busreq;
		logic        mem_rd;
		logic [23:0] mem_adr;
		logic [7:0]  data;
		logic [3:0]  pin;       // pulse pins after mode mux
		logic        display_off_out;
		logic        a0;
		logic        wr;
	} lcd_st_t;

	lcd_st_t s;      // registered state
	lcd_st_t next_s; // next state

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	logic       sr;       // serial shift mode
	logic       tick;     // rising edge of panel source clock
	logic       src;      // selected source, synchronised
	logic       ram_hit;  // cpu access falls in driver area
	logic [1:0] ram_idx;  // which enable
	logic [8:0] flen;     // frame length
	logic [7:0] rows;
	logic [5:0] cols;
	logic [5:0] per_max;  // last cycle of a step
	logic [2:0] step_max; // last step of a byte
	logic [7:0] rd_mux;

	assign sr   = s.sal[SAL_MODE];
	assign flen = {s.ctl[CTL_FP8], s.frame_length};
	assign rows = lcd_rows(s.size[7:4]);
	assign cols = lcd_cols(s.size[3:0]);
	// only second stages are read; the first flops feed nothing else
	assign src  = s.ecc[ECC_PANEL] ? s.t3_sync[1] : s.lf_sync[1];
	assign tick = src && !s.src_prev;

	// step timing per width; reserved width 11 runs as byte mode
	always_comb begin
		unique case (s.ctl[CTL_WLO+1:CTL_WLO])
			W_NIB: begin
				per_max  = PER_NIB - 6'd1;
				step_max = 3'd1;
			end
			W_BIT: begin
				per_max  = PER_BIT - 6'd1;
				step_max = 3'd7;
			end
			default: begin
				per_max  = PER_BYTE - 6'd1;
				step_max = 3'd0;
			end
		endcase
	end

	// sequential register area or 256k random area (64k per enable), per map bit
	always_comb begin
		if (s.ctl[CTL_MAP]) begin
			ram_hit = (cpu_adr_i[23:18] == RND_TAG);
			ram_idx = cpu_adr_i[17:16];
		end else begin
			ram_hit = (cpu_adr_i[23:3] == SEQ_TAG);
			ram_idx = cpu_adr_i[2:1];
		end
	end

	// register read mux; unmapped words read zero
	always_comb begin
		unique case (adr_i)
			IDX_SAL:  rd_mux = s.sal;
			IDX_SAH:  rd_mux = s.sah;
			IDX_SIZE: rd_mux = s.size;
			IDX_CTL:  rd_mux = s.ctl;
			IDX_FFP:  rd_mux = s.frame_length;
			IDX_CTL2: rd_mux = s.ctl2;
			IDX_ECC:  rd_mux = s.ecc;
			IDX_STAT: rd_mux = {5'h00, s.frame_lvl, s.busreq, s.st != S_IDLE};
			default:  rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// clock source synchronisers
		next_s.lf_sync  = {s.lf_sync[0], lf_clk_i};
		next_s.t3_sync  = {s.t3_sync[0], timer3_output_i};
		next_s.src_prev = src;
		// line latch and frame period, driven by the panel clock
		next_s.cd = 1'b0;
		if (s.lp != 3'd0) begin
			next_s.lp = s.lp - 3'd1;
		end
		if (sr && tick) begin
			next_s.lp = LATCH_CYC;
			if ({1'b0, s.line} + 10'd1 >= {1'b0, flen}) begin
				next_s.line      = 9'd0;
				next_s.frame_lvl = !s.frame_lvl;
				next_s.cd        = 1'b1;
			end else begin
				next_s.line = s.line + 9'd1;
			end
		end
		// frame transfer
		unique case (s.st)
			S_IDLE: begin
				if (sr && s.ctl[CTL_START]) begin
					next_s.st     = S_REQ;
					next_s.busreq = 1'b1;
					next_s.ofs    = 14'h0000;
					next_s.row    = 8'd0;
					next_s.col    = 6'd0;
				end
			end
			S_REQ: begin
				if (bus_grant_i) begin
					next_s.st     = S_FETCH;
					next_s.mem_rd = 1'b1;
				end
			end
			S_FETCH: begin
				if (mem_ack_i) begin
					next_s.sh     = mem_dat_i;
					next_s.mem_rd = 1'b0;
					next_s.ofs    = s.ofs + 14'd1;
					next_s.st     = S_SHIFT;
					next_s.per    = 6'd0;
					next_s.step   = 3'd0;
				end
			end
			S_SHIFT: begin
				if (s.per == per_max) begin
					next_s.per = 6'd0;
					if (s.step == step_max) begin
						next_s.step = 3'd0;
						if (s.col == cols - 6'd1) begin
							next_s.col = 6'd0;
							next_s.st  = S_LINE;
						end else begin
							next_s.col    = s.col + 6'd1;
							next_s.st     = S_FETCH;
							next_s.mem_rd = 1'b1;
						end
					end else begin
						next_s.step = s.step + 3'd1;
					end
				end else begin
					next_s.per = s.per + 6'd1;
				end
			end
			S_LINE: begin
				// the line is loaded by the next panel-clock latch pulse
				if (tick) begin
					if (s.row == rows - 8'd1) begin
						next_s.st              = S_IDLE;
						next_s.busreq          = 1'b0;
						next_s.ctl[CTL_START]  = 1'b0;
					end else begin
						next_s.row    = s.row + 8'd1;
						next_s.st     = S_FETCH;
						next_s.mem_rd = 1'b1;
					end
				end
			end
			default: begin
				next_s.st     = S_IDLE;
				next_s.busreq = 1'b0;
				next_s.mem_rd = 1'b0;
			end
		endcase
		// leaving shift mode mid-frame abandons the transfer and frees the bus
		if (!sr && s.st != S_IDLE) begin
			next_s.st     = S_IDLE;
			next_s.busreq = 1'b0;
			next_s.mem_rd = 1'b0;
		end
		next_s.mem_adr = {s.sah, s.sal[7:4], 12'h000} + {10'h000, next_s.ofs};
		// shift clock high in first half of a step; data moves on its rise, or at a byte's end while it is low
		next_s.sclk = (next_s.st == S_SHIFT) && (next_s.per <= {1'b0, per_max[5:1]});
		unique case (s.ctl[CTL_WLO+1:CTL_WLO])
			W_NIB:   next_s.data = {4'h0, next_s.step[0] ? next_s.sh[3:0] : next_s.sh[7:4]};
			W_BIT:   next_s.data = {7'h00, next_s.sh[3'd7 - next_s.step]};
			default: next_s.data = next_s.sh;
		endcase
		// ram mode chip enables; the cpu decides how many transfers happen
		next_s.ram_ce = 4'h0;
		next_s.wr     = 1'b0;
		if (!sr) begin
			if (s.hold != 2'd0) begin
				next_s.hold   = s.hold - 2'd1;
				next_s.ram_ce = s.ram_ce;
				next_s.wr     = s.wr;
			end
			if (cpu_acc_i && ram_hit) begin
				next_s.ram_ce = 4'h1 << ram_idx;
				next_s.a0     = cpu_adr_i[0];
				next_s.wr     = cpu_we_i;
				next_s.hold   = s.ctl2[CTL2_ACLO+1:CTL2_ACLO];
			end
		end
		// pulse pins double as enables outside shift mode
		next_s.pin  = sr ? {next_s.cd, next_s.frame_lvl, next_s.lp != 3'd0, next_s.sclk}
		                 : next_s.ram_ce;
		next_s.display_off_out = s.ctl[CTL_ON];
		// wishbone: ack one cycle, write lands on the edge the master sees ack
		next_s.ack = cyc_i && stb_i && !s.ack;
		if (cyc_i && stb_i && !s.ack) begin
			next_s.dat = rd_mux;
		end
		// software writes last, so a start write wins over the hardware clear
		if (cyc_i && stb_i && s.ack && we_i && sel_i[0]) begin
			unique case (adr_i)
				IDX_SAL:  next_s.sal  = dat_i[7:0];
				IDX_SAH:  next_s.sah  = dat_i[7:0];
				IDX_SIZE: next_s.size = dat_i[7:0];
				IDX_CTL:  next_s.ctl  = dat_i[7:0];
				IDX_FFP:  next_s.frame_length  = dat_i[7:0];
				IDX_CTL2: next_s.ctl2 = dat_i[7:0];
				IDX_ECC:  next_s.ecc  = {6'h00, dat_i[1:0]};
				default:  next_s.ctl2 = s.ctl2;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s    <= '0;
			s.st <= S_IDLE;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops
	assign dat_o                     = {24'h000000, s.dat};
	assign ack_o                     = s.ack;
	assign bus_req_o                 = s.busreq;
	assign mem_rd_o                  = s.mem_rd;
	assign mem_adr_o                 = s.mem_adr;
	assign lcd_data_o                = s.data;
	assign shift_clk_or_ce1_o        = s.pin[0];
	assign latch_pulse_or_ce2_o      = s.pin[1];
	assign frame_out_or_ce3_o        = s.pin[2];
	assign cascade_pulse_or_row_ce_o = s.pin[3];
	assign display_off_out_o         = s.display_off_out;
	assign lcd_a0_o                  = s.a0;
	assign lcd_wr_o                  = s.wr;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_IDLE_NO_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		s.st == S_IDLE |-> !bus_req_o) else $error("bus held while idle");
	AST_DONE_REARM: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(s.st) == S_LINE && s.st == S_IDLE && $past(sr))
		|-> !s.ctl[CTL_START] || $past(cyc_i && we_i)) else $error("start not cleared");
	AST_OFS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		s.st == S_REQ |-> s.ofs == 14'h0000) else $error("fetch offset not zero");
	AST_DISPLAY_OFF_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> display_off_out_o == $past(s.ctl[CTL_ON])) else $error("display pin lags");
	AST_CASCADE: assert property (@(posedge clk_i) disable iff (rst_i)
		(sr && $past(sr) && $changed(s.frame_lvl)) |-> cascade_pulse_or_row_ce_o
		##1 (!cascade_pulse_or_row_ce_o || !ce_i)) else $error("cascade pulse wrong");
	AST_FALL_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
		(sr && $fell(shift_clk_or_ce1_o)) |-> $stable(lcd_data_o)) else $error("data moved");
	AST_NIBBLE: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(s.ctl[CTL_WLO+1:CTL_WLO]) == W_NIB && $past(ce_i)) |-> lcd_data_o[7:4] == 4'h0)
		else $error("upper lines driven");
	AST_NO_WR_SR: assert property (@(posedge clk_i) disable iff (rst_i)
		(sr && $past(sr)) |-> !lcd_wr_o) else $error("write strobe in shift mode");
	AST_RAM_CE: assert property (@(posedge clk_i) disable iff (rst_i)
		(!sr && ce_i && cpu_acc_i && ram_hit) |=> s.pin == (4'h1 << $past(ram_idx)))
		else $error("wrong chip enable");
	COV_FRAME: cover property (@(posedge clk_i) s.st == S_LINE ##1 s.st == S_IDLE);
	COV_TOGGLE: cover property (@(posedge clk_i) sr && cascade_pulse_or_row_ce_o);
	COV_RAM_WR: cover property (@(posedge clk_i) !sr && lcd_wr_o && lcd_a0_o);
endmodule
`default_nettype wire

// File: tb/lcd_panel_model.sv
// far side of the panel controller: bus arbiter, frame memory, driver capture
// assumes the bench clock; memory latency set by slow_i, capture by width_i
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
	import lcd_pkg::*;
(
	// clock and bench control
	input  wire logic        clk_i,
	input  wire logic        clr_i,
	input  wire logic        slow_i,
	input  wire logic [1:0]  width_i,
	// arbiter and memory
	input  wire logic        bus_req_i,
	output logic             bus_grant_o,
	input  wire logic        mem_rd_i,
	input  wire logic [23:0] mem_adr_i,
	output logic      [7:0]  mem_dat_o,
	output logic             mem_ack_o,
	// driver pins
	input  wire logic [7:0]  data_i,
	input  wire logic        sck_i,
	input  wire logic        lp_i,
	input  wire logic        fr_i,
	input  wire logic        cd_i
);
	// ----------------------------------------
	// captured state, read by the bench
	// ----------------------------------------
	logic [7:0] cap [0:1023];   // assembled pixel bytes
	logic [7:0] sr = 8'h00;     // byte being assembled
	logic [2:0] wt = 3'h0;      // memory wait count
	logic       p_sck = 1'b0, p_lp = 1'b0, p_fr = 1'b0, p_cd = 1'b0;
	int         ncap = 0, ncasc = 0, nfr = 0, lines = 0, per = 0, gap = 0, min_gap = 255, nb = 0;
	initial begin
		bus_grant_o = 1'b0;
		mem_ack_o = 1'b0;
		mem_dat_o = 8'h00;
	end
	// grant follows request a cycle late; memory answers after a wait
	always @(posedge clk_i) begin
		bus_grant_o <= bus_req_i;
		mem_ack_o <= 1'b0;
		mem_dat_o <= ~mem_dat_o; // released lines never hold a stale byte
		if (mem_rd_i && !mem_ack_o) begin
			if (wt >= {1'b0, slow_i, 1'b0}) begin
				mem_ack_o <= 1'b1;
				mem_dat_o <= mem_adr_i[7:0] ^ 8'hA5;
				wt = 3'h0;
			end else
				wt = wt + 3'h1;
		end
	end
	// driver side: data taken on shift clock fall, line and frame counting
	always @(posedge clk_i) begin
		gap = gap + 1;
		if (clr_i) begin
			min_gap = 255;
			nb = 0;
		end
		if (p_sck && !sck_i) begin
			if (gap < min_gap)
				min_gap = gap;
			gap = 0;
			if (width_i == W_BIT)
				sr = {sr[6:0], data_i[0]};
			else if (width_i == W_NIB)
				sr = {sr[3:0], data_i[3:0]};
			else
				sr = data_i;
			nb = nb + ((width_i == W_BIT) ? 1 : (width_i == W_NIB) ? 4 : 8);
			if (nb >= 8) begin
				cap[ncap] = sr;
				ncap = ncap + 1;
				nb = 0;
			end
		end
		if (!p_lp && lp_i)
			lines = lines + 1;
		if (!p_cd && cd_i)
			ncasc = ncasc + 1;
		if (p_fr != fr_i) begin
			nfr = nfr + 1;
			per = lines;
			lines = 0;
		end
		p_sck = sck_i;
		p_lp = lp_i;
		p_fr = fr_i;
		p_cd = cd_i;
	end
endmodule
`default_nettype wire

// File: tb/lcd_ctrl_tb_top.sv
// bench for the panel controller: registers, ram mode enables, frame transfers
// assumes lcd_panel_model on the far side and a free-running 160 ns panel clock
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_tb_top
	import lcd_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, lf_clk = 1'b0, t3 = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, acc = 1'b0, cwe = 1'b0;
	logic        clr = 1'b0, slow = 1'b0, ack, bus_req, grant, mem_rd, mem_ack;
	logic        sck, lp, fr, cd, display_off_out, a0, wr;
	logic [1:0]  wmode = 2'h0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] wdat = 32'h0, dat_o;
	logic [23:0] cadr = 24'h0, mem_adr;
	logic [7:0]  mem_dat, lcd_data, q;
	int          num_errors = 0, checks_done = 0, cycles = 0, n, s, nc, nf;
	logic [9:0]  ridx [8] = '{IDX_SAL, IDX_SAH, IDX_SIZE, IDX_CTL, IDX_FFP, IDX_CTL2, IDX_ECC, 10'h365};
	logic [7:0]  rval [8] = '{8'hF1, 8'hA5, 8'h98, 8'h96, 8'hFF, 8'h07, 8'h01, 8'hFF};
	logic [1:0]  wtab [3] = '{W_BYTE, W_NIB, W_BIT};
	lcd_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack),
		.lf_clk_i(lf_clk), .timer3_output_i(t3), .bus_req_o(bus_req),
		.bus_grant_i(grant), .mem_rd_o(mem_rd), .mem_adr_o(mem_adr), .mem_dat_i(mem_dat),
		.mem_ack_i(mem_ack), .cpu_acc_i(acc), .cpu_we_i(cwe), .cpu_adr_i(cadr),
		.lcd_data_o(lcd_data), .shift_clk_or_ce1_o(sck), .latch_pulse_or_ce2_o(lp),
		.frame_out_or_ce3_o(fr), .cascade_pulse_or_row_ce_o(cd), .display_off_out_o(display_off_out),
		.lcd_a0_o(a0), .lcd_wr_o(wr));
	lcd_panel_model M (.clk_i(clk_i), .clr_i(clr), .slow_i(slow), .width_i(wmode),
		.bus_req_i(bus_req), .bus_grant_o(grant), .mem_rd_i(mem_rd), .mem_adr_i(mem_adr),
		.mem_dat_o(mem_dat), .mem_ack_o(mem_ack), .data_i(lcd_data), .sck_i(sck),
		.lp_i(lp), .fr_i(fr), .cd_i(cd));
	// ----------------------------------------
	// clocks and hang guard
	// ----------------------------------------
	always #10 clk_i = ~clk_i;
	// panel clock offset so it never lines up with the system clock
	initial begin
		#7;
		forever #80 lf_clk = ~lf_clk;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			num_errors = num_errors + 1;
			stop_test();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// classic single cycle; held until ack is seen, then one idle cycle
	// no local limit: only the bench timeout ends a wait for ack
	task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= idx;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_o[7:0];
		chk("bus answer", 1, ack);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wait_req(input logic v, input int lim);
		while (bus_req !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (ridx[i]) begin
			wb(1'b0, ridx[i], 8'h00);
			chk("reset value", 8'h00, q);
		end
		chk("display", 0, display_off_out);
		// unmapped index last: write ignored, reads zero
		foreach (ridx[i]) begin
			wb(1'b1, ridx[i], rval[i]);
			wb(1'b0, ridx[i], 8'h00);
			chk("readback", (i == 7) ? 8'h00 : rval[i], q);
		end
		chk("display", 1, display_off_out);
		foreach (ridx[i])
			wb(1'b1, ridx[i], 8'h00);
		// ram mode: every sequential driver address, one access each
		for (int a = 0; a < 8; a++) begin
			cadr <= 24'h000FE0 + 24'(a);
			cwe <= a[2];
			acc <= 1'b1;
			@(posedge clk_i);
			acc <= 1'b0;
			@(posedge clk_i);
			chk("chip enables", 1 << a[2:1], {cd, fr, lp, sck});
			chk("a0", a[0], a0);
			chk("write strobe", a[2], wr);
			@(posedge clk_i);
		end
		// random area with access type 2: each enable stands three cycles
		wb(1'b1, IDX_CTL, 8'h04);
		wb(1'b1, IDX_CTL2, 8'h02);
		for (int a = 0; a < 4; a++) begin
			cadr <= {6'h0F, a[1:0], 16'h0001};
			cwe <= 1'b1;
			acc <= 1'b1;
			@(posedge clk_i);
			acc <= 1'b0;
			@(posedge clk_i);
			chk("random enables", 1 << a[1:0], {cd, fr, lp, sck});
			chk("random a0", 1, a0);
			repeat (2) @(posedge clk_i);
			chk("enable hold", 1 << a[1:0], {cd, fr, lp, sck});
			@(posedge clk_i);
			chk("enable end", 0, {cd, fr, lp, sck});
		end
		wb(1'b1, IDX_CTL, 8'h00);
		wb(1'b1, IDX_CTL2, 8'h00);
		// shift mode: 64 rows by 32 columns, frame length equal to rows
		wb(1'b1, IDX_SAH, 8'h12);
		wb(1'b1, IDX_FFP, 8'h40);
		wb(1'b1, IDX_SAL, 8'h51);
		// timer source selected while it stands still: no latch pulses at all
		wb(1'b1, IDX_ECC, 8'h01);
		nc = M.lines;
		repeat (100) @(posedge clk_i);
		chk("timer source", nc, M.lines);
		wb(1'b1, IDX_ECC, 8'h00);
		foreach (wtab[j]) begin
			wmode <= wtab[j];
			slow <= wtab[j][0];
			clr <= 1'b1;
			@(posedge clk_i);
			clr <= 1'b0;
			s = M.ncap;
			nc = M.ncasc;
			nf = M.nfr;
			wb(1'b1, IDX_CTL, {3'b100, wtab[j], 3'b001});
			n = 0;
			wait_req(1'b1, 100);
			chk("bus request", 1, bus_req);
			chk("fetch base", 24'h125000, mem_adr);
			wait_req(1'b0, 40000);
			chk("bus release", 0, bus_req);
			for (int k = 0; k < 256; k++)
				chk("pixel byte", k[7:0] ^ 8'hA5, M.cap[s + k]);
			chk("lines per frame", 64, M.per);
			chk("cascade pulses", M.nfr - nf, M.ncasc - nc);
			if (wtab[j] != W_BYTE)
				chk("shift step", (wtab[j] == W_NIB) ? PER_NIB : PER_BIT, M.min_gap);
			chk("write strobe idle", 0, wr);
			wb(1'b0, IDX_CTL, 8'h00);
			chk("start bit", 0, q[0]);
		end
		stop_test();
	end
endmodule
`default_nettype wire
